// >>> common/alert_filter_params.svh
`ifndef ALERT_FILTER_PARAMS_SVH
`define ALERT_FILTER_PARAMS_SVH

// register addresses
`define OVERCURRENT_COUNT_ADDR  8'h44
`define UNDERCURRENT_COUNT_ADDR 8'h45
`define OVERPOWER_COUNT_ADDR    8'h46
`define OVERVOLTAGE_COUNT_ADDR  8'h47
`define ALERT_ENABLE_ADDR       8'h49
`define ALERT_ENABLE_HI_ADDR    8'h4a
`define REFRESH_ADDR            8'h4b

// reset values
`define COUNT_REG_RESET  8'h00
`define ALERT_EN_RESET   16'h0000

// channel field positions inside a count register (low bit of the pair)
`define FIELD_CH1_LSB 6
`define FIELD_CH2_LSB 4
`define FIELD_CH3_LSB 2
`define FIELD_CH4_LSB 0

// sample counts selected by the 2-bit codes
`define SAMPLES_CODE0 5'd1
`define SAMPLES_CODE1 5'd4
`define SAMPLES_CODE2 5'd8
`define SAMPLES_CODE3 5'd16

`endif

// >>> common/alert_filter_pkg.sv
package alert_filter_pkg;

    typedef enum logic [1:0] {
        kind_overcurrent,
        kind_undercurrent,
        kind_overpower,
        kind_overvoltage
    } alert_kind_t;

    // one completed conversion: limit comparator results per kind and channel
    typedef struct packed {
        logic       done;
        logic [3:0] overcurrent;
        logic [3:0] undercurrent;
        logic [3:0] overpower;
        logic [3:0] overvoltage;
    } conversion_t;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [3:0] overcurrent;
        logic [3:0] undercurrent;
        logic [3:0] overpower;
        logic [3:0] overvoltage;
    } alert_vec_t;

endpackage

// >>> src/sample_qualifier.sv
`timescale 1ns/100ps
`include "alert_filter_params.svh"

module sample_qualifier (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       conv_done,
    input  wire logic       beyond_limit,
    input  wire logic [1:0] count_code,
    output logic            qualified
);
    logic [4:0] run_q;
    logic [4:0] need;

    always_comb begin
        case (count_code)
            2'b00:   need = `SAMPLES_CODE0;
            2'b01:   need = `SAMPLES_CODE1;
            2'b10:   need = `SAMPLES_CODE2;
            default: need = `SAMPLES_CODE3;
        endcase
    end

    // counter only moves on a completed conversion
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            run_q <= 5'd0;
        end else if (conv_done) begin
            if (!beyond_limit) begin
                run_q <= 5'd0;
            end else if (run_q < need) begin
                run_q <= run_q + 5'd1;
            end
        end
    end

    // lowered code after qualifying keeps it qualified, since run_q >= need
    assign qualified = (run_q >= need) && (run_q != 5'd0);

endmodule

// >>> src/alert_consecutive_sample_filter.sv
// Operation
// - A 2-bit count code selects 1, 4, 8 or 16 consecutive samples for codes 00, 01, 10 and 11.
// - After reset every count field is 00 so one sample beyond the limit triggers its alert.
// - The overcurrent count register holds channel 2 in bits 5-4, channel 3 in 3-2, channel 4 in 1-0.
// - An undercurrent alert rises only after the programmed run of samples below the limit.
// - An overpower alert rises only after the programmed run of samples above the limit.
// - An overvoltage alert rises only after the programmed run of samples above the limit.
// - Undercurrent, overpower and overvoltage registers hold channel 1 in bits 7-6 down to channel 4 in 1-0.
// - Undercurrent, overpower and overvoltage counts live in 8-bit read/write registers at 45h, 46h, 47h.
// - A channel counter clears only when a completed conversion shows the condition gone.
// - A qualified condition reaches the alert output only if enabled, and new enables act after refresh.
`timescale 1ns/100ps
`include "alert_filter_params.svh"

module alert_consecutive_sample_filter (
    input  wire logic                         core_clk,
    input  wire logic                         reset_n,
    input  wire alert_filter_pkg::reg_req_t   reg_req,
    output logic [7:0]                        reg_rdata,
    output logic                              reg_rvalid,
    input  wire alert_filter_pkg::conversion_t conv,
    output alert_filter_pkg::alert_vec_t      alert_status,
    output logic                              alert_out
);
    import alert_filter_pkg::*;

    logic [7:0]  overcurrent_count_q;
    logic [7:0]  undercurrent_count_q;
    logic [7:0]  overpower_count_q;
    logic [7:0]  overvoltage_count_q;
    logic [15:0] enable_q;
    logic [15:0] enable_active_q;
    // per kind and channel, channel 1 in the top bit
    alert_vec_t  qual;
    logic [15:0] gated;
    logic        wr_hit;
    logic        rd_hit;

    // count fields, channel 1 in the top pair
    logic [1:0]  overcurrent_count_ch2;
    logic [1:0]  overcurrent_count_ch3;
    logic [1:0]  overcurrent_count_ch4;
    logic [1:0]  undercurrent_count_ch1;
    logic [1:0]  undercurrent_count_ch2;
    logic [1:0]  undercurrent_count_ch3;
    logic [1:0]  undercurrent_count_ch4;
    logic [1:0]  overpower_count_ch1;
    logic [1:0]  overpower_count_ch2;
    logic [1:0]  overpower_count_ch3;
    logic [1:0]  overpower_count_ch4;
    logic [1:0]  overvoltage_count_ch1;
    logic [1:0]  overvoltage_count_ch2;
    logic [1:0]  overvoltage_count_ch3;
    logic [1:0]  overvoltage_count_ch4;

    assign wr_hit = reg_req.write;
    assign rd_hit = reg_req.read;

    // count registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            overcurrent_count_q  <= `COUNT_REG_RESET;
            undercurrent_count_q <= `COUNT_REG_RESET;
            overpower_count_q    <= `COUNT_REG_RESET;
            overvoltage_count_q  <= `COUNT_REG_RESET;
        end else if (wr_hit) begin
            case (reg_req.addr)
                `OVERCURRENT_COUNT_ADDR:  overcurrent_count_q  <= {2'b00, reg_req.wdata[5:0]};
                `UNDERCURRENT_COUNT_ADDR: undercurrent_count_q <= reg_req.wdata;
                `OVERPOWER_COUNT_ADDR:    overpower_count_q    <= reg_req.wdata;
                `OVERVOLTAGE_COUNT_ADDR:  overvoltage_count_q  <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    // enables: overcurrent 15-12, undercurrent 11-8, overpower 7-4, overvoltage 3-0
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            enable_q <= `ALERT_EN_RESET;
        end else if (wr_hit && reg_req.addr == `ALERT_ENABLE_ADDR) begin
            enable_q[7:0] <= reg_req.wdata;
        end else if (wr_hit && reg_req.addr == `ALERT_ENABLE_HI_ADDR) begin
            enable_q[15:8] <= reg_req.wdata;
        end
    end

    // own refresh address, so a half-written enable pair never acts
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            enable_active_q <= `ALERT_EN_RESET;
        end else if (wr_hit && reg_req.addr == `REFRESH_ADDR) begin
            enable_active_q <= enable_q;
        end
    end

    // overcurrent channel 1 count is held outside this block
    assign overcurrent_count_ch2  = overcurrent_count_q[`FIELD_CH2_LSB +: 2];
    assign overcurrent_count_ch3  = overcurrent_count_q[`FIELD_CH3_LSB +: 2];
    assign overcurrent_count_ch4  = overcurrent_count_q[`FIELD_CH4_LSB +: 2];
    assign undercurrent_count_ch1 = undercurrent_count_q[`FIELD_CH1_LSB +: 2];
    assign undercurrent_count_ch2 = undercurrent_count_q[`FIELD_CH2_LSB +: 2];
    assign undercurrent_count_ch3 = undercurrent_count_q[`FIELD_CH3_LSB +: 2];
    assign undercurrent_count_ch4 = undercurrent_count_q[`FIELD_CH4_LSB +: 2];
    assign overpower_count_ch1    = overpower_count_q[`FIELD_CH1_LSB +: 2];
    assign overpower_count_ch2    = overpower_count_q[`FIELD_CH2_LSB +: 2];
    assign overpower_count_ch3    = overpower_count_q[`FIELD_CH3_LSB +: 2];
    assign overpower_count_ch4    = overpower_count_q[`FIELD_CH4_LSB +: 2];
    assign overvoltage_count_ch1  = overvoltage_count_q[`FIELD_CH1_LSB +: 2];
    assign overvoltage_count_ch2  = overvoltage_count_q[`FIELD_CH2_LSB +: 2];
    assign overvoltage_count_ch3  = overvoltage_count_q[`FIELD_CH3_LSB +: 2];
    assign overvoltage_count_ch4  = overvoltage_count_q[`FIELD_CH4_LSB +: 2];

    // overcurrent filters
    sample_qualifier overcurrent_ch1_qualifier (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .conv_done    (conv.done),
        .beyond_limit (conv.overcurrent[3]),
        .count_code   (2'b00), // count field lives elsewhere, one sample here
        .qualified    (qual.overcurrent[3])
    );

    sample_qualifier overcurrent_ch2_qualifier (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .conv_done    (conv.done),
        .beyond_limit (conv.overcurrent[2]),
        .count_code   (overcurrent_count_ch2),
        .qualified    (qual.overcurrent[2])
    );

    sample_qualifier overcurrent_ch3_qualifier (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .conv_done    (conv.done),
        .beyond_limit (conv.overcurrent[1]),
        .count_code   (overcurrent_count_ch3),
        .qualified    (qual.overcurrent[1])
    );

    sample_qualifier overcurrent_ch4_qualifier (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .conv_done    (conv.done),
        .beyond_limit (conv.overcurrent[0]),
        .count_code   (overcurrent_count_ch4),
        .qualified    (qual.overcurrent[0])
    );

    // undercurrent filters
    sample_qualifier undercurrent_ch1_qualifier (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .conv_done    (conv.done),
        .beyond_limit (conv.undercurrent[3]),
        .count_code   (undercurrent_count_ch1),
        .qualified    (qual.undercurrent[3])
    );

    sample_qualifier undercurrent_ch2_qualifier (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .conv_done    (conv.done),
        .beyond_limit (conv.undercurrent[2]),
        .count_code   (undercurrent_count_ch2),
        .qualified    (qual.undercurrent[2])
    );

    sample_qualifier undercurrent_ch3_qualifier (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .conv_done    (conv.done),
        .beyond_limit (conv.undercurrent[1]),
        .count_code   (undercurrent_count_ch3),
        .qualified    (qual.undercurrent[1])
    );

    sample_qualifier undercurrent_ch4_qualifier (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .conv_done    (conv.done),
        .beyond_limit (conv.undercurrent[0]),
        .count_code   (undercurrent_count_ch4),
        .qualified    (qual.undercurrent[0])
    );

    // overpower filters
    sample_qualifier overpower_ch1_qualifier (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .conv_done    (conv.done),
        .beyond_limit (conv.overpower[3]),
        .count_code   (overpower_count_ch1),
        .qualified    (qual.overpower[3])
    );

    sample_qualifier overpower_ch2_qualifier (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .conv_done    (conv.done),
        .beyond_limit (conv.overpower[2]),
        .count_code   (overpower_count_ch2),
        .qualified    (qual.overpower[2])
    );

    sample_qualifier overpower_ch3_qualifier (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .conv_done    (conv.done),
        .beyond_limit (conv.overpower[1]),
        .count_code   (overpower_count_ch3),
        .qualified    (qual.overpower[1])
    );

    sample_qualifier overpower_ch4_qualifier (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .conv_done    (conv.done),
        .beyond_limit (conv.overpower[0]),
        .count_code   (overpower_count_ch4),
        .qualified    (qual.overpower[0])
    );

    // overvoltage filters
    sample_qualifier overvoltage_ch1_qualifier (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .conv_done    (conv.done),
        .beyond_limit (conv.overvoltage[3]),
        .count_code   (overvoltage_count_ch1),
        .qualified    (qual.overvoltage[3])
    );

    sample_qualifier overvoltage_ch2_qualifier (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .conv_done    (conv.done),
        .beyond_limit (conv.overvoltage[2]),
        .count_code   (overvoltage_count_ch2),
        .qualified    (qual.overvoltage[2])
    );

    sample_qualifier overvoltage_ch3_qualifier (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .conv_done    (conv.done),
        .beyond_limit (conv.overvoltage[1]),
        .count_code   (overvoltage_count_ch3),
        .qualified    (qual.overvoltage[1])
    );

    sample_qualifier overvoltage_ch4_qualifier (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .conv_done    (conv.done),
        .beyond_limit (conv.overvoltage[0]),
        .count_code   (overvoltage_count_ch4),
        .qualified    (qual.overvoltage[0])
    );

    assign gated = qual & enable_active_q;

    // registered status
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            alert_status <= '0;
        end else begin
            alert_status <= gated;
        end
    end

    // registered pin, same edge as the status
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            alert_out <= 1'b0;
        end else begin
            alert_out <= |gated;
        end
    end

    // read port; unmapped addresses and the write-only refresh read zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= rd_hit;
            if (rd_hit) begin
                case (reg_req.addr)
                    `OVERCURRENT_COUNT_ADDR:  reg_rdata <= overcurrent_count_q;
                    `UNDERCURRENT_COUNT_ADDR: reg_rdata <= undercurrent_count_q;
                    `OVERPOWER_COUNT_ADDR:    reg_rdata <= overpower_count_q;
                    `OVERVOLTAGE_COUNT_ADDR:  reg_rdata <= overvoltage_count_q;
                    `ALERT_ENABLE_ADDR:       reg_rdata <= enable_q[7:0];
                    `ALERT_ENABLE_HI_ADDR:    reg_rdata <= enable_q[15:8];
                    default:                  reg_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule

// >>> verif/filter_props.sv
`timescale 1ns/100ps
module filter_props (
    input wire logic                          core_clk,
    input wire logic                          reset_n,
    input wire alert_filter_pkg::reg_req_t    reg_req,
    input wire logic [7:0]                    reg_rdata,
    input wire logic                          reg_rvalid,
    input wire alert_filter_pkg::conversion_t conv,
    input wire alert_filter_pkg::alert_vec_t  alert_status,
    input wire logic                          alert_out
);
    import alert_filter_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    chk_read_answer: assert property (reg_req.read |=> reg_rvalid)
        else $error("read not answered");
    chk_answer_cause: assert property (reg_rvalid |-> $past(reg_req.read))
        else $error("answer without read");
    chk_data_holds: assert property (!reg_req.read |=> $stable(reg_rdata))
        else $error("read data moved");
    chk_write_readback: assert property (reg_req.write && reg_req.addr == 8'h45 ##1 !reg_req.write ##1
        reg_req.read && reg_req.addr == 8'h45 |=> reg_rdata == $past(reg_req.wdata, 3))
        else $error("readback differs");
    chk_overcurrent_top_zero: assert property (reg_req.read && reg_req.addr == 8'h44
        |=> reg_rdata[7:6] == 2'b00)
        else $error("overcurrent top bits set");
    chk_unmapped_zero: assert property (reg_req.read && (reg_req.addr < 8'h44 || reg_req.addr > 8'h4a)
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_out_is_or: assert property (alert_out == (|alert_status))
        else $error("alert out not OR of status");
    chk_quiet_stable: assert property ((!conv.done && !reg_req.write) [*3] |-> $stable(alert_status))
        else $error("status moved without conversion");
    chk_rise_cause: assert property ($rose(alert_out) |-> $past(conv.done, 2) || $past(reg_req.write, 2))
        else $error("alert rose without cause");
endmodule

// >>> verif/alert_consecutive_sample_filter_test.sv
`timescale 1ns/100ps
module alert_consecutive_sample_filter_test;
    import alert_filter_pkg::*;
    logic        core_clk = 1'b0;
    logic        reset_n  = 1'b0;
    reg_req_t    req      = '0;
    conversion_t conv     = '0;
    logic [7:0]  rdata;
    logic        rvalid;
    alert_vec_t  status;
    logic        alert_out;
    int          bad_count = 0;
    int          compares  = 0;

    always #10 core_clk = ~core_clk;

    alert_consecutive_sample_filter alert_consecutive_sample_filter_inst (
        .core_clk(core_clk), .reset_n(reset_n), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .conv(conv), .alert_status(status), .alert_out(alert_out));

    task check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task print_verdict;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        req <= '0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        req <= '0;
        #1;
        check({7'h00, rvalid, rdata}, {8'h01, exp});
    endtask

    // both enable bytes, then the refresh write that makes them active
    task set_en(input logic [7:0] v);
        wr(8'h49, v);
        wr(8'h4a, v);
        wr(8'h4b, v);
    endtask

    task sample(input logic b);
        @(posedge core_clk);
        conv <= '{done: 1'b1, overcurrent: {4{b}}, undercurrent: {4{b}}, overpower: {4{b}}, overvoltage: {4{b}}};
        @(posedge core_clk);
        conv <= '0;
        @(posedge core_clk);
        #1;
    endtask

    function automatic logic [3:0] due(input logic [7:0] cb, input int k);
        for (int i = 0; i < 4; i++)
            due[i] = k >= (cb[2*i+:2] == 2'b00 ? 1 : 2 << cb[2*i+:2]);
    endfunction

    // overcurrent ch1 is not held in the count register, so it always needs one sample
    function automatic alert_vec_t expect_at(input logic [7:0] cb, input int k);
        return '{overcurrent: due({2'b00, cb[5:0]}, k), undercurrent: due(cb, k),
                 overpower: due(cb, k), overvoltage: due(cb, k)};
    endfunction

    task gated;
        wr(8'h49, 8'hff);
        wr(8'h4a, 8'hff);
        sample(1'b1);
        check(status, 16'h0000);
        check({15'h0000, alert_out}, 16'h0000);
        sample(1'b0);
        set_en(8'hff);
        sample(1'b1);
        check(status, 16'hffff);
        sample(1'b0);
        check(status, 16'h0000);
    endtask

    task regs;
        set_en(8'h00);
        rd(8'h44, 8'h00);
        rd(8'h45, 8'h00);
        rd(8'h46, 8'h00);
        rd(8'h47, 8'h00);
        wr(8'h45, 8'h1b);
        rd(8'h45, 8'h1b);
        wr(8'h46, 8'he4);
        rd(8'h46, 8'he4);
        wr(8'h47, 8'ha5);
        rd(8'h47, 8'ha5);
        wr(8'h44, 8'hff);
        rd(8'h44, 8'h3f);
        rd(8'h40, 8'h00);
        wr(8'h49, 8'h5a);
        rd(8'h49, 8'h5a);
        wr(8'h4a, 8'h3c);
        rd(8'h4a, 8'h3c);
        rd(8'h4b, 8'h00);
    endtask

    task run(input logic [7:0] cb);
        set_en(8'h00);
        wr(8'h44, cb);
        wr(8'h45, cb);
        wr(8'h46, cb);
        wr(8'h47, cb);
        set_en(8'hff);
        for (int k = 1; k <= 16; k++) begin
            sample(1'b1);
            check(status, expect_at(cb, k));
        end
        sample(1'b0);
        check(status, 16'h0000);
        repeat (3) sample(1'b1);
        sample(1'b0);
        repeat (3) sample(1'b1);
        check(status, expect_at(cb, 3));
        check({15'h0000, alert_out}, 16'h0001);
        sample(1'b0);
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        gated;
        regs;
        run(8'h00);
        run(8'h55);
        run(8'haa);
        run(8'hff);
        run(8'h1b);
        run(8'he4);
        print_verdict;
    end

    initial begin
        #100000;
        bad_count++;
        print_verdict;
    end
endmodule

bind alert_consecutive_sample_filter filter_props filter_props_inst (
    .core_clk(core_clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .conv(conv), .alert_status(alert_status), .alert_out(alert_out));
